//--- logic/acm_entry_matcher.sv
`timescale 1ns/1ps
`include "acm_regs.svh"

// Behaviour
// - Host mode: destination equals configured address
// - Network mode: destination compared under mask
// - Next-header any always passes
// - Specific next-header must equal configured value
// - ICMP/UDP/TCP choice restricts and enables checks
// - Source any passes every IPv6 frame
// - Source compare uses low 32 bits only
// - Zero mask bit makes address bit don't-care
// - Hop zero blocks frames with nonzero hop
// - Hop nonzero needs hop above zero; any passes
// - ICMP type any always passes
// - Specific ICMP type must equal configured value
// - ICMP code any always passes
// - Specific ICMP code must equal configured value
// - Source port any always passes
// - Specific source port must equal configured value
module acm_entry_matcher
   import acm_pkg::*;
(
   input wire logic clock_in,
   input wire logic nrst_in,
   input wire logic ce_in,
   input wire acm_wb_req_t wb_req_in,
   output logic [31:0] wb_dat_out,
   output logic wb_ack_out,
   input wire acm_hdr_t hdr_in,
   output logic match_out,
   output logic match_valid_out
);

   // Register image and its next value
   acm_state_t st_r;
   acm_state_t st_nxt;

   // Decoded configuration
   logic v6_entry;
   acm_dst_mode_t dst_mode;
   acm_nh_mode_t nh_mode;
   acm_sel_t src_sel;
   acm_hop_mode_t hop_mode;
   acm_sel_t itype_sel;
   acm_sel_t icode_sel;
   acm_sel_t sport_sel;
   logic [7:0] nh_val;
   logic [7:0] itype_val;
   logic [7:0] icode_val;

   // Comparator results
   logic dst_eq;
   logic src_eq;
   logic [31:0] dst_eff_mask;

   // Per-check verdicts
   logic dst_ok;
   logic nh_ok;
   logic src_ok;
   logic hop_ok;
   logic icmp_chk;
   logic port_chk;
   logic icmp_ok;
   logic port_ok;
   logic hit;

   // Bus decode
   logic req;
   logic wr_commit;

   // Field decode of the control and values words
   always_comb begin
      v6_entry = st_r.ctrl[`ACM_CTRL_V6_BIT];
      dst_mode = acm_dst_mode_t'(st_r.ctrl[`ACM_CTRL_DST_LSB +: 2]);
      nh_mode = acm_nh_mode_t'(st_r.ctrl[`ACM_CTRL_NH_LSB +: 3]);
      src_sel = acm_sel_t'(st_r.ctrl[`ACM_CTRL_SRC_BIT]);
      hop_mode = acm_hop_mode_t'(st_r.ctrl[`ACM_CTRL_HOP_LSB +: 2]);
      itype_sel = acm_sel_t'(st_r.ctrl[`ACM_CTRL_ITYPE_BIT]);
      icode_sel = acm_sel_t'(st_r.ctrl[`ACM_CTRL_ICODE_BIT]);
      sport_sel = acm_sel_t'(st_r.ctrl[`ACM_CTRL_SPORT_BIT]);
      nh_val = st_r.values[`ACM_VAL_NH_LSB +: 8];
      itype_val = st_r.values[`ACM_VAL_ITYPE_LSB +: 8];
      icode_val = st_r.values[`ACM_VAL_ICODE_LSB +: 8];
   end

   // Host mode reuses the masked compare with every bit significant
   assign dst_eff_mask = (dst_mode == DST_HOST) ? `ACM_RST_MASK : st_r.dst_mask;

   // Destination address comparator
   acm_mask_cmp #(.W(32)) u_dst_cmp (
      .a_in(hdr_in.v4_dst),
      .b_in(st_r.dst_addr),
      .mask_in(dst_eff_mask),
      .eq_out(dst_eq)
   );

   // Only the low word of the IPv6 source is ever seen here
   acm_mask_cmp #(.W(32)) u_src_cmp (
      .a_in(hdr_in.v6_src_lo),
      .b_in(st_r.src_addr),
      .mask_in(st_r.src_mask),
      .eq_out(src_eq)
   );

   // Field checks of one entry
   always_comb begin
      // Destination address
      case (dst_mode)
         DST_ANY: dst_ok = 1'b1;
         DST_HOST: dst_ok = dst_eq;
         DST_NETWORK: dst_ok = dst_eq;
         default: dst_ok = 1'b0;
      endcase
      // Next header, with protocol extras
      icmp_chk = 1'b0;
      port_chk = 1'b0;
      case (nh_mode)
         NH_ANY: nh_ok = 1'b1;
         NH_SPECIFIC: nh_ok = (hdr_in.next_hdr == nh_val);
         NH_ICMP: begin
            nh_ok = (hdr_in.next_hdr == `ACM_PROTO_ICMP);
            icmp_chk = 1'b1;
         end
         NH_UDP: begin
            nh_ok = (hdr_in.next_hdr == `ACM_PROTO_UDP);
            port_chk = 1'b1;
         end
         NH_TCP: begin
            nh_ok = (hdr_in.next_hdr == `ACM_PROTO_TCP);
            port_chk = 1'b1;
         end
         // Unused codes never match, safer than passing
         default: nh_ok = 1'b0;
      endcase
      // Source address
      case (src_sel)
         SEL_ANY: src_ok = 1'b1;
         SEL_SPECIFIC: src_ok = src_eq;
         default: src_ok = 1'b0;
      endcase
      // Hop limit
      case (hop_mode)
         HOP_ANY: hop_ok = 1'b1;
         HOP_ZERO: hop_ok = (hdr_in.hop_limit == 8'h00);
         HOP_NONZERO: hop_ok = (hdr_in.hop_limit != 8'h00);
         default: hop_ok = 1'b0;
      endcase
      // ICMP type and code, only for ICMP selection
      icmp_ok = !icmp_chk || (((itype_sel == SEL_ANY) || (hdr_in.icmp_type == itype_val)) &&
                ((icode_sel == SEL_ANY) || (hdr_in.icmp_code == icode_val)));
      // Source port, only for TCP or UDP selection
      port_ok = !port_chk || (sport_sel == SEL_ANY) || (hdr_in.src_port == st_r.sport);
      // Combined verdict for the entry's frame family
      if (v6_entry) begin
         hit = hdr_in.is_ipv6 && nh_ok && src_ok && hop_ok && icmp_ok && port_ok;
      end else begin
         hit = hdr_in.is_ipv4 && dst_ok;
      end
   end

   // A write lands on the edge where the master sees ack
   assign req = wb_req_in.cyc && wb_req_in.stb;
   assign wr_commit = req && wb_req_in.we && st_r.ack;

   // Byte-lane merge of a write into an old word
   function automatic logic [31:0] lane_merge(input logic [31:0] old_w, input logic [31:0] new_w,
                                              input logic [3:0] sel);
      logic [31:0] res;
      res = old_w;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            res[8*i +: 8] = new_w[8*i +: 8];
         end
      end
      return res;
   endfunction

   // Next state: bus slave, config writes, match result
   always_comb begin
      logic [31:0] wv;
      wv = 32'h0000_0000;
      st_nxt = st_r;
      // Ack one cycle after the request, dropped the next cycle
      st_nxt.ack = req && !st_r.ack;
      // Read mux, registered; unmapped reads give zero
      if (req && !st_r.ack) begin
         case (wb_req_in.adr)
            `ACM_OFS_CTRL: st_nxt.rdat = {20'h00000, st_r.ctrl};
            `ACM_OFS_DST_ADDR: st_nxt.rdat = st_r.dst_addr;
            `ACM_OFS_DST_MASK: st_nxt.rdat = st_r.dst_mask;
            `ACM_OFS_SRC_ADDR: st_nxt.rdat = st_r.src_addr;
            `ACM_OFS_SRC_MASK: st_nxt.rdat = st_r.src_mask;
            `ACM_OFS_VALUES: st_nxt.rdat = {8'h00, st_r.values};
            `ACM_OFS_SPORT: st_nxt.rdat = {16'h0000, st_r.sport};
            `ACM_OFS_STATUS: st_nxt.rdat = {st_r.hit_cnt, 15'h0000, st_r.match};
            default: st_nxt.rdat = 32'h0000_0000;
         endcase
      end
      // Writes; unmapped and status writes are dropped
      if (wr_commit) begin
         case (wb_req_in.adr)
            `ACM_OFS_CTRL: begin
               wv = lane_merge({20'h00000, st_r.ctrl}, wb_req_in.dat, wb_req_in.sel);
               st_nxt.ctrl = wv[`ACM_CTRL_W-1:0];
            end
            `ACM_OFS_DST_ADDR: st_nxt.dst_addr = lane_merge(st_r.dst_addr, wb_req_in.dat, wb_req_in.sel);
            `ACM_OFS_DST_MASK: st_nxt.dst_mask = lane_merge(st_r.dst_mask, wb_req_in.dat, wb_req_in.sel);
            `ACM_OFS_SRC_ADDR: st_nxt.src_addr = lane_merge(st_r.src_addr, wb_req_in.dat, wb_req_in.sel);
            `ACM_OFS_SRC_MASK: st_nxt.src_mask = lane_merge(st_r.src_mask, wb_req_in.dat, wb_req_in.sel);
            `ACM_OFS_VALUES: begin
               wv = lane_merge({8'h00, st_r.values}, wb_req_in.dat, wb_req_in.sel);
               st_nxt.values = wv[23:0];
            end
            `ACM_OFS_SPORT: begin
               wv = lane_merge({16'h0000, st_r.sport}, wb_req_in.dat, wb_req_in.sel);
               st_nxt.sport = wv[15:0];
            end
            default: st_nxt.hit_cnt = st_r.hit_cnt;
         endcase
      end
      // One verdict per valid header, held until the next
      st_nxt.mvalid = hdr_in.valid;
      if (hdr_in.valid) begin
         st_nxt.match = hit;
         // Hit counter wraps; software reads it as a rate hint
         if (hit) begin
            st_nxt.hit_cnt = st_r.hit_cnt + 16'h0001;
         end
      end
   end

   // State register; clock enable freezes everything
   always_ff @(posedge clock_in or negedge nrst_in) begin
      if (!nrst_in) begin
         st_r.ctrl <= `ACM_RST_CTRL;
         st_r.dst_addr <= `ACM_RST_WORD;
         st_r.dst_mask <= `ACM_RST_MASK;
         st_r.src_addr <= `ACM_RST_WORD;
         st_r.src_mask <= `ACM_RST_MASK;
         st_r.values <= 24'h000000;
         st_r.sport <= 16'h0000;
         st_r.hit_cnt <= 16'h0000;
         st_r.ack <= 1'b0;
         st_r.rdat <= `ACM_RST_WORD;
         st_r.match <= 1'b0;
         st_r.mvalid <= 1'b0;
      end else if (ce_in) begin
         st_r <= st_nxt;
      end
   end

   // Outputs straight from flops
   assign wb_dat_out = st_r.rdat;
   assign wb_ack_out = st_r.ack;
   assign match_out = st_r.match;
   assign match_valid_out = st_r.mvalid;

   // Checks on the verdict and the bus ack
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (!nrst_in);

   sequence s_v4_eval;
      ce_in && hdr_in.valid && !v6_entry && hdr_in.is_ipv4;
   endsequence

   sequence s_v6_eval;
      ce_in && hdr_in.valid && v6_entry && hdr_in.is_ipv6;
   endsequence

   sequence s_rejected;
      match_valid_out && !match_out;
   endsequence

   AST_DST_HOST: assert property (s_v4_eval and (dst_mode == DST_HOST && hdr_in.v4_dst != st_r.dst_addr)
      |=> s_rejected) else $error("host mode matched a foreign destination");
   AST_DST_NET: assert property (s_v4_eval and (dst_mode == DST_NETWORK &&
      ((hdr_in.v4_dst ^ st_r.dst_addr) & st_r.dst_mask) == 32'h0000_0000)
      |=> match_valid_out && match_out) else $error("network mode missed a masked hit");
   AST_NH_ANY: assert property (s_v6_eval and (st_r.ctrl[11:1] == 11'h000)
      |=> match_out) else $error("all don't-care entry missed");
   AST_NH_SPEC: assert property (s_v6_eval and (nh_mode == NH_SPECIFIC && hdr_in.next_hdr != nh_val)
      |=> s_rejected) else $error("specific next header mismatch matched");
   AST_NH_TCP: assert property (s_v6_eval and (nh_mode == NH_TCP && hdr_in.next_hdr != `ACM_PROTO_TCP)
      |=> s_rejected) else $error("TCP selection matched another protocol");
   AST_SRC: assert property (s_v6_eval and (src_sel == SEL_SPECIFIC &&
      ((hdr_in.v6_src_lo ^ st_r.src_addr) & st_r.src_mask) != 32'h0000_0000)
      |=> s_rejected) else $error("source mask mismatch matched");
   AST_HOP_ZERO: assert property (s_v6_eval and (hop_mode == HOP_ZERO && hdr_in.hop_limit != 8'h00)
      |=> s_rejected) else $error("hop zero entry matched nonzero hop");
   AST_ICMP_TYPE: assert property (s_v6_eval and (nh_mode == NH_ICMP && itype_sel == SEL_SPECIFIC &&
      hdr_in.icmp_type != itype_val) |=> s_rejected) else $error("ICMP type mismatch matched");
   AST_SPORT: assert property (s_v6_eval and (nh_mode == NH_UDP && sport_sel == SEL_SPECIFIC &&
      hdr_in.src_port != st_r.sport) |=> s_rejected) else $error("source port mismatch matched");
   AST_VALID: assert property (ce_in && !hdr_in.valid |=> !match_valid_out && $stable(match_out))
      else $error("verdict changed without a header");
   AST_WB_ACK: assert property (ce_in && req && !wb_ack_out ##1 ce_in |=> !wb_ack_out)
      else $error("ack held longer than one cycle");

endmodule

//--- logic/acm_mask_cmp.sv
`timescale 1ns/1ps
// Masked equality: a zero mask bit is don't-care
module acm_mask_cmp #(
   parameter int W = 32
) (
   input wire logic [W-1:0] a_in,
   input wire logic [W-1:0] b_in,
   input wire logic [W-1:0] mask_in,
   output logic eq_out
);
   assign eq_out = ((a_in & mask_in) == (b_in & mask_in));
endmodule

//--- logic/acm_pkg.sv
package acm_pkg;

   // Destination address check mode
   typedef enum logic [1:0] {DST_ANY, DST_HOST, DST_NETWORK} acm_dst_mode_t;

   // IPv6 next-header selection
   typedef enum logic [2:0] {NH_ANY, NH_SPECIFIC, NH_ICMP, NH_UDP, NH_TCP} acm_nh_mode_t;

   // Hop-limit selection
   typedef enum logic [1:0] {HOP_ANY, HOP_ZERO, HOP_NONZERO} acm_hop_mode_t;

   // Plain any / specific selection
   typedef enum logic {SEL_ANY, SEL_SPECIFIC} acm_sel_t;

   // Header fields from the parser
   typedef struct packed {
      logic valid;
      logic is_ipv4;
      logic is_ipv6;
      logic [31:0] v4_dst;
      logic [31:0] v6_src_lo;
      logic [7:0] next_hdr;
      logic [7:0] hop_limit;
      logic [7:0] icmp_type;
      logic [7:0] icmp_code;
      logic [15:0] src_port;
   } acm_hdr_t;

   // Wishbone request from the master
   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [7:0] adr;
      logic [3:0] sel;
      logic [31:0] dat;
   } acm_wb_req_t;

   // Whole state of the matcher
   typedef struct packed {
      logic [11:0] ctrl;
      logic [31:0] dst_addr;
      logic [31:0] dst_mask;
      logic [31:0] src_addr;
      logic [31:0] src_mask;
      logic [23:0] values;
      logic [15:0] sport;
      logic [15:0] hit_cnt;
      logic ack;
      logic [31:0] rdat;
      logic match;
      logic mvalid;
   } acm_state_t;

endpackage

//--- logic/acm_regs.svh
`ifndef ACM_REGS_SVH
`define ACM_REGS_SVH

// Register byte offsets
`define ACM_OFS_CTRL 8'h00
`define ACM_OFS_DST_ADDR 8'h04
`define ACM_OFS_DST_MASK 8'h08
`define ACM_OFS_SRC_ADDR 8'h0C
`define ACM_OFS_SRC_MASK 8'h10
`define ACM_OFS_VALUES 8'h14
`define ACM_OFS_SPORT 8'h18
`define ACM_OFS_STATUS 8'h1C

// Control register fields
`define ACM_CTRL_W 12
`define ACM_CTRL_V6_BIT 0
`define ACM_CTRL_DST_LSB 1
`define ACM_CTRL_NH_LSB 3
`define ACM_CTRL_SRC_BIT 6
`define ACM_CTRL_HOP_LSB 7
`define ACM_CTRL_ITYPE_BIT 9
`define ACM_CTRL_ICODE_BIT 10
`define ACM_CTRL_SPORT_BIT 11

// Values register fields
`define ACM_VAL_NH_LSB 0
`define ACM_VAL_ITYPE_LSB 8
`define ACM_VAL_ICODE_LSB 16

// Status register fields
`define ACM_STAT_MATCH_BIT 0
`define ACM_STAT_CNT_LSB 16

// Reset values
`define ACM_RST_CTRL 12'h000
`define ACM_RST_WORD 32'h0000_0000
`define ACM_RST_MASK 32'hFFFF_FFFF

// IPv6 next-header codes of the carried protocols
`define ACM_PROTO_ICMP 8'h3A
`define ACM_PROTO_UDP 8'h11
`define ACM_PROTO_TCP 8'h06

`endif

//--- testbench/acm_entry_matcher_tb.sv
`timescale 1ns/1ps
`include "acm_regs.svh"
// Self-checking bench for one access_rule_entry matcher
module acm_entry_matcher_tb;
   import acm_pkg::*;
   logic clock_in = 1'b0;
   logic nrst_in = 1'b0;
   logic ce_in = 1'b1; // Held high except during the clock enable stall test
   logic send = 1'b0;
   acm_wb_req_t wb_req = '0;
   acm_hdr_t hdr_src = '0;
   acm_hdr_t hdr;
   logic [31:0] wb_dat;
   logic wb_ack;
   logic match;
   logic mvalid;
   int err_total = 0;
   int n_checks = 0;
   logic [31:0] seed = 32'h0000_1E6D; // Fixed seed, repeatable runs
   logic [31:0] cfg [0:6]; // Mirror of the configuration, one word per register
   logic [31:0] wmask [0:6] = '{32'h0000_0FFF, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'hFFFF_FFFF,
      32'hFFFF_FFFF, 32'h00FF_FFFF, 32'h0000_FFFF};
   logic [31:0] rst_val [0:8] = '{32'h0, 32'h0, 32'hFFFF_FFFF, 32'h0, 32'hFFFF_FFFF, 32'h0, 32'h0, 32'h0, 32'h0};

   // 250 MHz clock
   always #2 clock_in = ~clock_in;

   acm_entry_matcher DUT (.clock_in(clock_in), .nrst_in(nrst_in), .ce_in(ce_in), .wb_req_in(wb_req),
      .wb_dat_out(wb_dat), .wb_ack_out(wb_ack), .hdr_in(hdr), .match_out(match), .match_valid_out(mvalid));
   acm_parser_model PARSER (.clock_in(clock_in), .nrst_in(nrst_in), .send_in(send), .hdr_in(hdr_src),
      .hdr_out(hdr));

   // Xorshift step
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction

   task automatic rnd(output logic [31:0] v);
      seed = xs(seed);
      v = seed;
   endtask

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // Word results
   task automatic check32(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Verdict results
   task automatic check1(input logic got, input logic exp);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Classic Wishbone cycle; ack sampled at each rising edge, data taken and request released at that edge
   task automatic wb_cycle(input logic we, input logic [7:0] adr, input logic [31:0] dat, output logic [31:0] rd);
      int n;
      wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hF, dat: dat};
      n = 0;
      do begin
         @(posedge clock_in);
         n++;
      end while (wb_ack !== 1'b1 && n < 50);
      rd = wb_dat;
      if (n >= 50) begin
         err_total++;
         print_verdict();
      end
      // One idle cycle before the next request
      wb_req <= '0;
      @(posedge clock_in);
   endtask

   // Worked-out verdict for a header against the mirrored configuration
   function automatic logic exp_match(input acm_hdr_t h);
      logic [11:0] c;
      logic ok;
      c = cfg[0][11:0];
      if (!c[0]) begin
         case (c[2:1])
            2'h0: ok = 1'b1;
            2'h1: ok = h.v4_dst == cfg[1];
            2'h2: ok = ((h.v4_dst ^ cfg[1]) & cfg[2]) == 32'h0;
            default: ok = 1'b0;
         endcase
         return h.is_ipv4 && ok;
      end
      case (c[5:3])
         3'h0: ok = 1'b1;
         3'h1: ok = h.next_hdr == cfg[5][7:0];
         3'h2: ok = h.next_hdr == `ACM_PROTO_ICMP && (!c[9] || h.icmp_type == cfg[5][15:8])
            && (!c[10] || h.icmp_code == cfg[5][23:16]);
         3'h3, 3'h4: ok = h.next_hdr == (c[3] ? `ACM_PROTO_UDP : `ACM_PROTO_TCP)
            && (!c[11] || h.src_port == cfg[6][15:0]);
         default: ok = 1'b0;
      endcase
      if (c[6] && ((h.v6_src_lo ^ cfg[3]) & cfg[4]) != 32'h0) ok = 1'b0;
      if ((c[8:7] == 2'h1 && h.hop_limit != 8'h0) || (c[8:7] == 2'h2 && h.hop_limit == 8'h0)
         || c[8:7] == 2'h3) ok = 1'b0;
      return h.is_ipv6 && ok;
   endfunction

   // Random header, often steered towards the configured values so matches happen
   function automatic acm_hdr_t make_hdr(input logic [31:0] r0, input logic [31:0] r1, input logic [31:0] r2);
      acm_hdr_t h;
      logic [5:0] m;
      h = acm_hdr_t'({r0, r1, r2, r0[18:0]});
      m = cfg[0][5:0];
      h.valid = 1'b1;
      h.is_ipv6 = r2[0] ? m[0] : r1[3];
      h.is_ipv4 = r2[9] ? ~h.is_ipv6 : r0[5];
      if (r2[1]) h.v4_dst = cfg[1] ^ (r1 & ~cfg[2]);
      if (r2[2]) h.v6_src_lo = cfg[3] ^ (r0 & ~cfg[4]);
      if (r2[3]) h.next_hdr = r2[4] ? cfg[5][7:0] : (m[5:3] == 3'h2 ? `ACM_PROTO_ICMP
         : (m[3] ? `ACM_PROTO_UDP : `ACM_PROTO_TCP));
      if (r2[5]) h.hop_limit = r2[10] ? 8'h00 : 8'h01;
      if (r2[6]) h.icmp_type = cfg[5][15:8];
      if (r2[7]) h.icmp_code = cfg[5][23:16];
      if (r2[8]) h.src_port = cfg[6][15:0];
      return h;
   endfunction

   // One header through the parser stand-in; verdict checked while valid pulses
   task automatic send_hdr(input acm_hdr_t h, output logic got);
      int n;
      hdr_src <= h;
      send <= 1'b1;
      @(posedge clock_in);
      send <= 1'b0;
      n = 0;
      do begin
         @(posedge clock_in);
         n++;
      end while (mvalid !== 1'b1 && n < 8);
      got = match;
      if (n >= 8) begin
         err_total++;
         print_verdict();
      end
      // The valid pulse lasts one cycle only
      @(posedge clock_in);
      check1(mvalid, 1'b0);
   endtask

   // Main sequence
   initial begin
      logic [31:0] r0, r1, r2, rd;
      logic got, e, last;
      logic [15:0] hits;
      acm_hdr_t h;
      hits = 16'h0;
      last = 1'b0;
      repeat (5) @(posedge clock_in);
      nrst_in <= 1'b1;
      @(posedge clock_in);
      // Reset values, then an unmapped write that must leave nothing behind
      for (int i = 0; i < 9; i++) begin
         wb_cycle(1'b0, 8'(i * 4), 32'h0, rd);
         check32(rd, rst_val[i]);
      end
      wb_cycle(1'b1, 8'h20, 32'hFFFF_FFFF, rd);
      wb_cycle(1'b0, 8'h20, 32'h0, rd);
      check32(rd, 32'h0);
      $display("test reset and map done");
      for (int k = 0; k < 40; k++) begin
         for (int i = 0; i < 7; i++) begin
            rnd(r0);
            cfg[i] = r0 & wmask[i];
            wb_cycle(1'b1, 8'(i * 4), r0, rd);
            wb_cycle(1'b0, 8'(i * 4), 32'h0, rd);
            check32(rd, cfg[i]);
         end
         for (int j = 0; j < 12; j++) begin
            rnd(r0);
            rnd(r1);
            rnd(r2);
            h = make_hdr(r0, r1, r2);
            e = exp_match(h);
            send_hdr(h, got);
            check1(got, e);
            hits = hits + 16'(e);
            last = e;
         end
         wb_cycle(1'b0, `ACM_OFS_STATUS, 32'h0, rd);
         check32(rd, {hits, 15'h0, last});
         $display("test round %0d done", k);
      end
      // Clock enable low: a request and a header arrive, yet nothing may move
      ce_in <= 1'b0;
      wb_req <= '{cyc: 1'b1, stb: 1'b1, we: 1'b0, adr: `ACM_OFS_STATUS, sel: 4'hF, dat: 32'h0};
      hdr_src <= make_hdr(r0, r1, r2);
      send <= 1'b1;
      @(posedge clock_in);
      send <= 1'b0;
      repeat (3) @(posedge clock_in);
      check1(wb_ack, 1'b0);
      check1(mvalid, 1'b0);
      check1(match, last);
      wb_req <= '0;
      @(posedge clock_in);
      ce_in <= 1'b1;
      @(posedge clock_in);
      $display("test clock enable stall done");
      // Second reset in mid-run
      nrst_in <= 1'b0;
      repeat (2) @(posedge clock_in);
      nrst_in <= 1'b1;
      @(posedge clock_in);
      wb_cycle(1'b0, `ACM_OFS_CTRL, 32'h0, rd);
      check32(rd, 32'h0);
      // Hit count and last verdict cleared by reset
      wb_cycle(1'b0, `ACM_OFS_STATUS, 32'h0, rd);
      check32(rd, 32'h0);
      $display("test second reset done");
      print_verdict();
   end
endmodule

//--- testbench/acm_parser_model.sv
`timescale 1ns/1ps
// Stand-in for the frame header parser: one valid cycle per header
module acm_parser_model
   import acm_pkg::*;
(
   input wire logic clock_in,
   input wire logic nrst_in,
   input wire logic send_in,
   input wire acm_hdr_t hdr_in,
   output acm_hdr_t hdr_out
);
   // Idle fields are inverted each cycle so stale values never pass for live ones
   always_ff @(posedge clock_in or negedge nrst_in) begin
      if (!nrst_in) begin
         hdr_out <= '0;
      end else if (send_in) begin
         hdr_out <= hdr_in;
      end else begin
         // Valid is the top bit of the packed header; one assignment keeps it low
         hdr_out <= {1'b0, ~hdr_out[$bits(acm_hdr_t)-2:0]};
      end
   end
endmodule
